//--- verilog/msd_pkg.sv
// constants and types shared by both ends of the shutdown sequencer
// assumes a 50 MHz core clock; ms counts use a 1 ms tick
package msd_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS         = 1000000;
  localparam int TICK_CYC      = MS_NS / CLK_PERIOD_NS;

  localparam logic [16:0] ON_PULSE_MS     = 17'd100;
  localparam logic [16:0] OFF_PULSE_MS    = 17'd2100;
  localparam logic [16:0] OFF_AFTER_UP_MS = 17'd36000;
  localparam logic [16:0] UNRESP_MS       = 17'd5000;
  localparam logic [16:0] PD_MS           = 17'd200;
  localparam logic [16:0] RTC_RST_MS      = 17'd2000;
  localparam logic [16:0] RESTART_IGN_MS  = 17'd100;
  localparam logic [16:0] GUARD_MS        = 17'd120000;
  localparam logic [16:0] SHUTDOWN_MS     = 17'd20000;
  localparam logic [16:0] UV_REP_MS       = 17'd1000;
  localparam logic [1:0]  UV_REPEATS      = 2'd3;

  localparam logic signed [7:0] T_HI2_ON  = 8'sd97;
  localparam logic signed [7:0] T_HI2_OFF = 8'sd96;
  localparam logic signed [7:0] T_HI1_ON  = 8'sd86;
  localparam logic signed [7:0] T_HI1_OFF = 8'sd85;
  localparam logic signed [7:0] T_LO1_ON  = -8'sd31;
  localparam logic signed [7:0] T_LO1_OFF = -8'sd30;
  localparam logic signed [7:0] T_LO2_ON  = -8'sd42;
  localparam logic signed [7:0] T_LO2_OFF = -8'sd40;

  localparam logic [12:0] OV_MARGIN_MV    = 13'd100;
  localparam logic [12:0] OV_WARN_BAND_MV = 13'd50;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_ON    = 0;
  localparam int CTRL_OFF   = 1;
  localparam int CTRL_EOFF  = 2;
  localparam int CTRL_ERST  = 3;
  localparam int CTRL_ALIVE = 4;
  localparam int ST_PWR_OFF = 0;
  localparam int ST_BUSY    = 1;
  localparam int ST_REFUSED = 2;

  typedef enum logic [1:0] {
    EVT_TEMP, EVT_UV, EVT_OV_WARN, EVT_OV_SHUT
  } msd_evt_t;
  typedef logic signed [2:0] msd_lvl_t;
endpackage

//--- verilog/msd_link_if.sv
// link between host controller and module: ignition, emergency-off,
// power-off indicator; emergency-off is open drain with internal pull-up
`timescale 1ns/1ps
`default_nettype none
interface msd_link_if;
  logic ignition_line_n;
  logic emergency_off_o;
  logic emergency_off_oe;
  logic emergency_off_line;
  logic power_off_indicator;
  // pulled high unless the host sinks it
  assign emergency_off_line = emergency_off_oe ? emergency_off_o : 1'b1;
  modport host (output ignition_line_n, output emergency_off_o,
                output emergency_off_oe, input power_off_indicator,
                input emergency_off_line);
  modport device (input ignition_line_n, input emergency_off_line,
                  output power_off_indicator);
endinterface
`default_nettype wire

//--- verilog/msd_device.sv
// module end: power state, ignition/emergency handling, thermal and
// supply supervision with alert events; link pins are asynchronous
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (RULE_01) ignition on-only or on/off, off by default
// (RULE_02) ignition held 100ms when off switches on
// (RULE_03) ignition held 2.1s, switch off at release
// (RULE_04) ignition switch-off uses orderly shutdown
// (RULE_05) host waits 36s after startup before switch-off
// (RULE_06) host uses emergency-off only after 5s silence
// (RULE_07) emergency-off held until power-off indicator high
// (RULE_08) ignition high before release means stay off
// (RULE_09) emergency-off reaches power-down within 2000ms
// (RULE_10) emergency-off over 2000ms resets real-time clock
// (RULE_11) ignition low 100ms after release restarts
// (RULE_12) temperature or supply faults start orderly shutdown
// (RULE_13) alert on each temperature range change
// (RULE_14) warnings shown in mode 1 or guard period
// (RULE_15) critical alerts always shown, then shutdown
// (RULE_16) high thresholds 97/96 and 86/85 degrees
// (RULE_17) low thresholds -31/-30 and -42/-40 degrees
// (RULE_18) shutdown deferred by emergency call or guard
// (RULE_19) after deferral still critical, silent shutdown
// (RULE_20) undervoltage alert repeats, then shutdown
// (RULE_21) overvoltage warning once, shutdown alert, shutdown
// (RULE_22) supply alerts need no enable
// (RULE_23) signed level -2..+2 on strobed event output
module msd_device #(
  parameter int          TICK_CYC = msd_pkg::TICK_CYC,
  parameter logic [12:0] VMAX_MV  = 13'd4200,
  parameter logic [12:0] UV_MV    = 13'd3300
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  msd_link_if.device             link,
  input  wire logic              cfg_wr_i,
  input  wire logic              cfg_ign_off_en_i,
  input  wire logic              cfg_alert_mode_i,
  input  wire logic              sw_shutdown_i,
  input  wire logic              restart_i,
  input  wire logic              ecall_i,
  input  wire logic              call_active_i,
  input  wire logic              temp_valid_i,
  input  wire logic signed [7:0] board_temp_i,
  input  wire logic [12:0]       supply_mv_i,
  output logic                   evt_valid_o,
  output msd_pkg::msd_evt_t      evt_kind_o,
  output msd_pkg::msd_lvl_t      evt_level_o,
  output logic                   powered_o,
  output logic                   rtc_reset_o
);
  import msd_pkg::*;

  typedef enum logic [2:0] {
    D_OFF, D_ON, D_SHUT, D_EMRG, D_EPD, D_RST
  } msd_dst_t;

  function automatic logic [16:0] ms_inc(input logic [16:0] v);
    ms_inc = (v == 17'h1FFFF) ? v : v + 17'd1;
  endfunction

  msd_dst_t    st_q, st_d;
  logic [15:0] tick_cnt_q;
  logic [1:0]  s1_q, s2_q, s3_q, flt_q;
  logic [16:0] ign_ms_q, emg_ms_q, up_ms_q, st_ms_q, uv_ms_q;
  logic        ign_was_q, pwr_off_q, rtc_q, ign_off_en_q, mode_q;
  logic        call_ext_q, rst_pend_q, ov_warned_q, uv_prev_q;
  logic [1:0]  uv_cnt_q;
  msd_lvl_t    lvl_q;
  logic        evt_v_q;
  msd_evt_t    evt_k_q;
  msd_lvl_t    evt_l_q;

  wire tick    = tick_cnt_q == 16'(TICK_CYC - 1);
  wire ign_act = ~flt_q[0];
  wire emg_act = ~flt_q[1];
  wire ign_rel = ign_was_q & ~ign_act;
  wire on      = st_q == D_ON;
  wire guard   = up_ms_q < GUARD_MS;

  // hysteresis: a level is kept until its release threshold is passed
  msd_lvl_t lvl_n;
  assign lvl_n =
    (board_temp_i >= T_HI2_ON) ? 3'sd2 :                         // RULE_16
    (lvl_q == 3'sd2 && board_temp_i > T_HI2_OFF) ? 3'sd2 :
    (board_temp_i >= T_HI1_ON) ? 3'sd1 :
    (lvl_q >= 3'sd1 && board_temp_i > T_HI1_OFF) ? 3'sd1 :
    (board_temp_i <= T_LO2_ON) ? -3'sd2 :                        // RULE_17
    (lvl_q == -3'sd2 && board_temp_i < T_LO2_OFF) ? -3'sd2 :
    (board_temp_i <= T_LO1_ON) ? -3'sd1 :
    (lvl_q <= -3'sd1 && board_temp_i < T_LO1_OFF) ? -3'sd1 : 3'sd0;

  wire crit_n    = (lvl_n == 3'sd2) || (lvl_n == -3'sd2);
  wire crit      = (lvl_q == 3'sd2) || (lvl_q == -3'sd2);
  wire temp_chg  = on & temp_valid_i & (lvl_n != lvl_q);        // RULE_13
  wire temp_evt  = temp_chg & (crit_n | mode_q | guard);   // RULE_14 RULE_15
  wire defer     = ecall_i | guard | call_ext_q;                 // RULE_18
  wire temp_shut = on & crit & ~defer;                   // RULE_15 RULE_19

  wire [12:0] ov_thr = VMAX_MV + OV_MARGIN_MV;                   // RULE_21
  wire ov_shut     = on & (supply_mv_i > ov_thr);
  wire ov_near     = supply_mv_i > (ov_thr - OV_WARN_BAND_MV);
  wire ov_warn_evt = on & ov_near & ~ov_shut & ~ov_warned_q;     // RULE_21
  wire uv          = supply_mv_i < UV_MV;
  wire uv_due      = tick & (uv_ms_q == UV_REP_MS - 17'd1);
  wire uv_last     = uv_cnt_q == UV_REPEATS - 2'd1;
  wire uv_evt      = on & uv & (~uv_prev_q | (uv_due & ~uv_last)); // RULE_20
  wire uv_shut     = on & uv & uv_due & uv_last;                 // RULE_20

  wire ign_off  = ign_rel & ign_off_en_q &
                  (ign_ms_q >= OFF_PULSE_MS);              // RULE_01 RULE_03
  wire off_req  = ign_off | sw_shutdown_i | restart_i |          // RULE_04
                  temp_shut | ov_shut | uv_shut;                 // RULE_12
  wire st_done  = tick & (st_ms_q >= SHUTDOWN_MS - 17'd1);
  wire pd_done  = tick & (st_ms_q >= PD_MS - 17'd1);             // RULE_09

  always_comb begin
    st_d = st_q;
    if (emg_act && st_q != D_EMRG && st_q != D_EPD) begin
      st_d = D_EMRG;                                             // RULE_07
    end else begin
      unique case (st_q)
        D_OFF: if (ign_rel && ign_ms_q >= ON_PULSE_MS) st_d = D_ON; // RULE_02
        D_ON:   if (off_req) st_d = D_SHUT;
        D_SHUT: if (st_done) st_d = rst_pend_q ? D_ON : D_OFF;
        D_EMRG: if (pd_done) st_d = D_EPD;                       // RULE_09
        D_EPD: begin
          if (!emg_act) st_d = ign_act ? D_RST : D_OFF;   // RULE_08 RULE_11
        end
        D_RST: begin
          if (st_ms_q >= RESTART_IGN_MS) st_d = D_ON;            // RULE_11
          else if (!ign_act) st_d = D_OFF;
        end
      endcase
    end
  end

  // 3-stage synchroniser; a change counts when stages 2 and 3 agree
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          flt_q[gi] <= 1'b1;
        end else if (s2_q[gi] == s3_q[gi]) begin
          flt_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s1_q <= 2'h3;
      s2_q <= 2'h3;
      s3_q <= 2'h3;
    end else begin
      s1_q <= {link.emergency_off_line, link.ignition_line_n};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tick_cnt_q <= 16'h0000;
      ign_ms_q   <= 17'h00000;
      emg_ms_q   <= 17'h00000;
      ign_was_q  <= 1'b0;
      rtc_q      <= 1'b0;
    end else begin
      tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
      ign_was_q  <= ign_act;
      ign_ms_q   <= !ign_act ? 17'h00000 : tick ? ms_inc(ign_ms_q) : ign_ms_q;
      emg_ms_q   <= !emg_act ? 17'h00000 : tick ? ms_inc(emg_ms_q) : emg_ms_q;
      rtc_q      <= emg_act & tick & (emg_ms_q == RTC_RST_MS);   // RULE_10
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_q      <= D_OFF;
      st_ms_q   <= 17'h00000;
      up_ms_q   <= 17'h00000;
      pwr_off_q <= 1'b1;
    end else begin
      st_q      <= st_d;
      st_ms_q   <= (st_d != st_q) ? 17'h00000 :
                   tick ? ms_inc(st_ms_q) : st_ms_q;
      up_ms_q   <= (st_q != D_ON) ? 17'h00000 :
                   (tick && guard) ? up_ms_q + 17'd1 : up_ms_q;
      pwr_off_q <= (st_d == D_OFF) || (st_d == D_EPD);           // RULE_07
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ign_off_en_q <= 1'b0;                                      // RULE_01
      mode_q       <= 1'b0;
      call_ext_q   <= 1'b0;
      rst_pend_q   <= 1'b0;
    end else begin
      if (cfg_wr_i) begin
        ign_off_en_q <= cfg_ign_off_en_i;                        // RULE_01
        mode_q       <= cfg_alert_mode_i;
      end
      call_ext_q <= call_active_i & (call_ext_q | (on & guard)); // RULE_18
      if (on && restart_i) rst_pend_q <= 1'b1;
      else if (st_q != D_SHUT) rst_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !on) begin
      lvl_q       <= 3'sd0;
      ov_warned_q <= 1'b0;
      uv_prev_q   <= 1'b0;
      uv_cnt_q    <= 2'd0;
      uv_ms_q     <= 17'h00000;
    end else begin
      if (temp_chg) lvl_q <= lvl_n;                              // RULE_19
      if (ov_warn_evt) ov_warned_q <= 1'b1;
      uv_prev_q <= uv;
      uv_ms_q   <= !uv ? 17'h00000 : uv_due ? 17'h00000 :
                   tick ? uv_ms_q + 17'd1 : uv_ms_q;
      uv_cnt_q  <= !uv ? 2'd0 : (uv_due && !uv_last) ? uv_cnt_q + 2'd1
                   : uv_cnt_q;
    end
  end

  // one event per cycle: temperature, then overvoltage, then undervoltage
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      evt_v_q <= 1'b0;
      evt_k_q <= EVT_TEMP;
      evt_l_q <= 3'sd0;
    end else begin
      evt_v_q <= temp_evt | ov_shut | ov_warn_evt | uv_evt;      // RULE_22
      evt_l_q <= temp_evt ? lvl_n : 3'sd0;                       // RULE_23
      evt_k_q <= temp_evt ? EVT_TEMP : ov_shut ? EVT_OV_SHUT :
                 ov_warn_evt ? EVT_OV_WARN : EVT_UV;
    end
  end

  assign link.power_off_indicator = pwr_off_q;
  assign powered_o   = ~pwr_off_q;
  assign rtc_reset_o = rtc_q;
  assign evt_valid_o = evt_v_q;
  assign evt_kind_o  = evt_k_q;
  assign evt_level_o = evt_l_q;
endmodule // msd_device
`default_nettype wire

//--- verilog/msd_host.sv
// host end: APB registers drive ignition and emergency-off sequences
// assumes power-off indicator arrives asynchronously from the module
`timescale 1ns/1ps
`default_nettype none
module msd_host #(
  parameter int TICK_CYC = msd_pkg::TICK_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  msd_link_if.host         link,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);
  import msd_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE, H_ON, H_OFFW, H_OFF, H_EMRG, H_EREL
  } msd_hst_t;

  msd_hst_t    st_q, st_d;
  logic [15:0] tick_cnt_q;
  logic [2:0]  sy_q;
  logic        ind_q, erst_q, refused_q, ign_n_q, emg_oe_q;
  logic [16:0] st_ms_q, up_ms_q, silent_ms_q;
  logic [31:0] rdata_q;
  logic        err_q;

  wire tick    = tick_cnt_q == 16'(TICK_CYC - 1);
  wire setup   = psel_i & ~penable_i;
  wire acc     = psel_i & penable_i;
  wire hit_c   = paddr_i == ADDR_CTRL;
  wire hit_s   = paddr_i == ADDR_STATUS;
  wire cmd_wr  = acc & pwrite_i & hit_c;
  wire idle    = st_q == H_IDLE;
  wire want_on  = cmd_wr & pwdata_i[CTRL_ON];
  wire want_off = cmd_wr & pwdata_i[CTRL_OFF];
  wire want_em  = cmd_wr & (pwdata_i[CTRL_EOFF] | pwdata_i[CTRL_ERST]);
  wire em_ok    = silent_ms_q >= UNRESP_MS;                      // RULE_06
  wire take_on  = idle & want_on & ind_q;
  wire take_off = idle & want_off & ~ind_q;
  wire take_em  = idle & want_em & em_ok;
  wire any_cmd  = want_on | want_off | want_em;
  wire taken    = take_on | take_off | take_em;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      H_IDLE: begin
        if (take_em) st_d = H_EMRG;
        else if (take_on) st_d = H_ON;
        else if (take_off) st_d = H_OFFW;
      end
      // pulses run one ms past the limit: the module's count may start late
      H_ON:   if (st_ms_q > ON_PULSE_MS) st_d = H_IDLE;          // RULE_02
      H_OFFW: if (up_ms_q >= OFF_AFTER_UP_MS) st_d = H_OFF;      // RULE_05
      H_OFF:  if (st_ms_q > OFF_PULSE_MS) st_d = H_IDLE;         // RULE_03
      H_EMRG: if (ind_q) st_d = H_EREL;                          // RULE_07
      H_EREL: begin
        if (!erst_q || st_ms_q > RESTART_IGN_MS) st_d = H_IDLE;  // RULE_11
      end
    endcase
  end

  wire ign_low_d = (st_d == H_ON) || (st_d == H_OFF) ||
                   (erst_q && (st_d == H_EREL));                 // RULE_08
  wire [31:0] status = {29'h0, refused_q, ~idle, ind_q};

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sy_q  <= 3'h7;
      ind_q <= 1'b1;
    end else begin
      sy_q <= {sy_q[1:0], link.power_off_indicator};
      if (sy_q[1] == sy_q[2]) ind_q <= sy_q[2];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_q        <= H_IDLE;
      tick_cnt_q  <= 16'h0000;
      st_ms_q     <= 17'h00000;
      up_ms_q     <= 17'h00000;
      silent_ms_q <= 17'h00000;
      erst_q      <= 1'b0;
      refused_q   <= 1'b0;
      ign_n_q     <= 1'b1;
      emg_oe_q    <= 1'b0;
    end else begin
      st_q       <= st_d;
      tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
      st_ms_q    <= (st_d != st_q) ? 17'h00000 :
                    (tick && st_ms_q != 17'h1FFFF) ? st_ms_q + 17'd1 : st_ms_q;
      up_ms_q    <= ind_q ? 17'h00000 :
                    (tick && up_ms_q < OFF_AFTER_UP_MS) ? up_ms_q + 17'd1
                    : up_ms_q;
      if (cmd_wr && pwdata_i[CTRL_ALIVE]) silent_ms_q <= 17'h00000;
      else if (tick && !em_ok) silent_ms_q <= silent_ms_q + 17'd1;
      if (take_em) erst_q <= pwdata_i[CTRL_ERST];
      if (any_cmd) refused_q <= ~taken;
      ign_n_q  <= ~(ign_low_d || (erst_q && st_d == H_EMRG));
      emg_oe_q <= st_d == H_EMRG;                                // RULE_07
    end
  end

  // read data and error are captured in the setup cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else if (setup) begin
      rdata_q <= (hit_s && !pwrite_i) ? status : 32'h0000_0000;
      err_q   <= ~(hit_c | hit_s);
    end
  end

  assign prdata_o              = rdata_q;
  assign pslverr_o             = err_q;
  assign pready_o              = 1'b1;
  assign link.ignition_line_n  = ign_n_q;
  assign link.emergency_off_o  = 1'b0;
  assign link.emergency_off_oe = emg_oe_q;
endmodule // msd_host
`default_nettype wire

//--- test/msd_link_chk.sv
// checker for the host-to-module link of the shutdown sequencer
// assumes it sits beside msd_link_if with the tops' TICK_CYC value
`timescale 1ns/1ps
`default_nettype none
module msd_link_chk #(
  parameter int TICK_CYC = 2
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ignition_line_n,
  input wire logic emergency_off_o,
  input wire logic emergency_off_oe,
  input wire logic emergency_off_line,
  input wire logic power_off_indicator
);
  // first ms of a host count may be one tick short
  localparam int ON_CYC  = 99 * TICK_CYC;
  localparam int OFF_CYC = 2099 * TICK_CYC;
  localparam int UP_CYC  = 35999 * TICK_CYC;
  localparam int PD_CYC  = 2000 * TICK_CYC + 16;
  int ign_cnt_q;
  int up_cnt_q;
  int pd_cnt_q;
  logic off_try_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ign_cnt_q <= 0;
      up_cnt_q  <= 0;
      pd_cnt_q  <= 0;
      off_try_q <= 1'b0;
    end else begin
      ign_cnt_q <= ignition_line_n ? 0 : ign_cnt_q + 1;
      up_cnt_q  <= power_off_indicator ? 0 :
                   (up_cnt_q < UP_CYC ? up_cnt_q + 1 : up_cnt_q);
      pd_cnt_q  <= (emergency_off_line || power_off_indicator) ? 0 :
                   pd_cnt_q + 1;
      // remember whether the pulse began as a switch-off attempt
      if (!ignition_line_n && ign_cnt_q == 0)
        off_try_q <= !power_off_indicator && !emergency_off_oe;
    end
  end

  sequence s_rel_off;
    $rose(ignition_line_n) && power_off_indicator && !emergency_off_oe;
  endsequence
  sequence s_rel_on;
    $rose(ignition_line_n) && off_try_q && !power_off_indicator &&
      !emergency_off_oe;
  endsequence

  property p_on_len; s_rel_off |-> ign_cnt_q >= ON_CYC; endproperty
  a_on_len: assert property (p_on_len)
    else $error("switch-on pulse too short");
  property p_on_ans; s_rel_off |-> ##[1:16] !power_off_indicator; endproperty
  a_on_ans: assert property (p_on_ans)
    else $error("module did not switch on after pulse");
  property p_off_len; s_rel_on |-> ign_cnt_q >= OFF_CYC; endproperty
  a_off_len: assert property (p_off_len)
    else $error("switch-off pulse too short");
  property p_off_wait;
    $fell(ignition_line_n) && !power_off_indicator && !emergency_off_oe
      |-> up_cnt_q >= UP_CYC;
  endproperty
  a_off_wait: assert property (p_off_wait)
    else $error("switch-off pulse too soon after startup");
  property p_od_sink; emergency_off_oe |-> !emergency_off_o; endproperty
  a_od_sink: assert property (p_od_sink)
    else $error("emergency line driven high");
  property p_eoff_hold;
    emergency_off_oe && !power_off_indicator |=> emergency_off_oe;
  endproperty
  a_eoff_hold: assert property (p_eoff_hold)
    else $error("emergency line released before power-down");
  property p_pd_hold;
    power_off_indicator && !emergency_off_line |=> power_off_indicator;
  endproperty
  a_pd_hold: assert property (p_pd_hold)
    else $error("indicator dropped while emergency line low");
  property p_pd_bound; pd_cnt_q <= PD_CYC; endproperty
  a_pd_bound: assert property (p_pd_bound)
    else $error("power-down took too long");
  property p_perm_off;
    $fell(emergency_off_oe) && ignition_line_n |=> power_off_indicator [*8];
  endproperty
  a_perm_off: assert property (p_perm_off)
    else $error("module left power-down after permanent off");
endmodule // msd_link_chk
`default_nettype wire

//--- test/tb.sv
// self-checking bench: host and module ends joined over the link
// assumes a small tick parameter so the ms counts stay short
`timescale 1ns/1ps
`default_nettype none
module tb;
  import msd_pkg::*;
  localparam int TK = 2;
  localparam logic [12:0] MV_OK = 13'hED8;
  typedef struct {
    logic wr; logic [7:0] addr; logic [31:0] data, rd; logic err;
  } msd_arow_t;
  typedef struct {
    logic signed [7:0] temp; logic [12:0] mv; msd_evt_t kind; msd_lvl_t lvl;
  } msd_erow_t;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata, rd;
  logic              pready, pslverr, err;
  logic              cfg_wr = 1'b0;
  logic              cfg_off_en = 1'b0;
  logic              cfg_mode = 1'b0;
  logic              temp_valid = 1'b0;
  logic signed [7:0] temp = 8'sh19;
  logic [12:0]       mv = MV_OK;
  logic              evt_valid, powered, rtc;
  msd_evt_t          evt_kind;
  msd_lvl_t          evt_lvl;
  int                bad_count = 0;
  int                compares = 0;
  int                evt_count = 0;
  int                rtc_count = 0;
  int                n;
  msd_arow_t arows [8] = '{
    '{1'b0, ADDR_STATUS, 32'h0, 32'h1, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h0C, 32'h1, 32'h0, 1'b1},
    '{1'b0, ADDR_CTRL, 32'h0, 32'h0, 1'b0},
    '{1'b1, ADDR_CTRL, 32'h4, 32'h0, 1'b0}, // emergency too soon
    '{1'b0, ADDR_STATUS, 32'h0, 32'h5, 1'b0},
    '{1'b1, ADDR_CTRL, 32'h2, 32'h0, 1'b0}, // off while off
    '{1'b0, ADDR_STATUS, 32'h0, 32'h5, 1'b0}};
  msd_erow_t erows [11] = '{
    '{8'sh56, MV_OK, EVT_TEMP, 3'sh1}, // 86 degrees
    '{8'sh55, MV_OK, EVT_TEMP, 3'sh0}, // 85 degrees
    '{8'sh61, MV_OK, EVT_TEMP, 3'sh2}, // 97 degrees
    '{8'sh60, MV_OK, EVT_TEMP, 3'sh1}, // 96 degrees
    '{8'sh55, MV_OK, EVT_TEMP, 3'sh0},
    '{-8'sh1F, MV_OK, EVT_TEMP, -3'sh1}, // -31 degrees
    '{-8'sh1E, MV_OK, EVT_TEMP, 3'sh0}, // -30 degrees
    '{-8'sh2A, MV_OK, EVT_TEMP, -3'sh2}, // -42 degrees
    '{-8'sh28, MV_OK, EVT_TEMP, -3'sh1}, // -40 degrees
    '{-8'sh1E, MV_OK, EVT_TEMP, 3'sh0},
    '{-8'sh1E, 13'h10A4, EVT_OV_WARN, 3'sh0}}; // near limit

  msd_link_if msd_link_if_i ();
  msd_host #(.TICK_CYC(TK)) msd_host_i (.core_clk_i(clk), .rst_i(rst),
    .link(msd_link_if_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
  msd_device #(.TICK_CYC(TK)) msd_device_i (.core_clk_i(clk), .rst_i(rst),
    .link(msd_link_if_i), .cfg_wr_i(cfg_wr), .cfg_ign_off_en_i(cfg_off_en),
    .cfg_alert_mode_i(cfg_mode), .sw_shutdown_i(1'b0), .restart_i(1'b0),
    .ecall_i(1'b0), .call_active_i(1'b0), .temp_valid_i(temp_valid),
    .board_temp_i(temp), .supply_mv_i(mv), .evt_valid_o(evt_valid),
    .evt_kind_o(evt_kind), .evt_level_o(evt_lvl), .powered_o(powered),
    .rtc_reset_o(rtc));
  msd_link_chk #(.TICK_CYC(TK)) msd_link_chk_i (.core_clk_i(clk),
    .rst_i(rst), .ignition_line_n(msd_link_if_i.ignition_line_n),
    .emergency_off_o(msd_link_if_i.emergency_off_o),
    .emergency_off_oe(msd_link_if_i.emergency_off_oe),
    .emergency_off_line(msd_link_if_i.emergency_off_line),
    .power_off_indicator(msd_link_if_i.power_off_indicator));

  always #10 clk = ~clk;
  always @(posedge clk) if (evt_valid === 1'b1) evt_count++;
  always @(posedge clk) if (rtc === 1'b1) rtc_count++;

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic timeout(input string nm);
    bad_count++;
    $display("wrong value %s expected done seen timeout", nm);
    print_verdict();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) timeout("pready");
  endtask
  // sel 0 waits for an event pulse, sel 1 for a powered level
  task automatic waitfor(input logic sel, input logic v, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge clk);
      if ((sel ? powered : evt_valid) === v) return;
    end
    timeout(sel ? "powered" : "event");
  endtask
  task automatic idle_wait();
    for (int i = 0; i < 2000; i++) begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      if (rd[ST_BUSY] === 1'b0) return;
    end
    timeout("busy");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    cfg_wr <= 1'b1;
    cfg_off_en <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    @(negedge clk);
    chk("powered", 32'(powered), 32'h0);
    chk("ignition", 32'(msd_link_if_i.ignition_line_n), 32'h1);
    chk("eoff_oe", 32'(msd_link_if_i.emergency_off_oe), 32'h0);
    chk("indicator", 32'(msd_link_if_i.power_off_indicator), 32'h1);
    repeat (8) @(posedge clk);
    foreach (arows[k]) begin
      apb(arows[k].wr, arows[k].addr, arows[k].data);
      if (!arows[k].wr)
        chk("prdata", rd, arows[k].rd);
      chk("pslverr", 32'(err), 32'(arows[k].err));
    end
    apb(1'b1, ADDR_CTRL, 32'h1);
    waitfor(1'b1, 1'b1, 400 * TK);
    chk("indicator", 32'(msd_link_if_i.power_off_indicator), 32'h0);
    foreach (erows[k]) begin
      @(posedge clk);
      temp <= erows[k].temp;
      mv <= erows[k].mv;
      temp_valid <= 1'b1;
      @(posedge clk);
      temp_valid <= 1'b0;
      waitfor(1'b0, 1'b1, 64);
      chk("evt_kind", 32'(evt_kind), 32'(erows[k].kind));
      chk("evt_level", 32'(evt_lvl), 32'(erows[k].lvl));
      chk("powered", 32'(powered), 32'h1);
    end
    apb(1'b1, ADDR_CTRL, 32'h10);
    n = evt_count;
    repeat (5001 * TK) @(posedge clk);
    chk("evt_count", 32'(evt_count), 32'(n));
    apb(1'b1, ADDR_CTRL, 32'h4);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("refused", 32'(rd[ST_REFUSED]), 32'h0);
    waitfor(1'b1, 1'b0, 2100 * TK);
    idle_wait();
    chk("ignition", 32'(msd_link_if_i.ignition_line_n), 32'h1);
    chk("eoff_oe", 32'(msd_link_if_i.emergency_off_oe), 32'h0);
    chk("powered", 32'(powered), 32'h0);
    chk("rtc_count", 32'(rtc_count), 32'h0);
    @(posedge clk);
    mv <= MV_OK;
    apb(1'b1, ADDR_CTRL, 32'h1);
    waitfor(1'b1, 1'b1, 400 * TK);
    @(posedge clk);
    mv <= 13'hBB8;
    for (int j = 0; j < 3; j++) begin
      waitfor(1'b0, 1'b1, 1100 * TK);
      chk("evt_kind", 32'(evt_kind), 32'(EVT_UV));
      chk("powered", 32'(powered), 32'h1);
    end
    waitfor(1'b1, 1'b0, 22000 * TK);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
